// ### design/adc_pkg.sv
package adc_pkg;

    // Register indices; byte address is the index times four
    localparam logic [31:0] RES_A_IDX    = 32'h05fffee0;
    localparam logic [31:0] RES_B_IDX    = 32'h05fffee2;
    localparam logic [31:0] RES_C_IDX    = 32'h05fffee4;
    localparam logic [31:0] RES_D_IDX    = 32'h05fffee6;
    localparam logic [31:0] CTRL_IDX     = 32'h05fffef8;
    localparam logic [31:0] IRQ_STAT_IDX = 32'h05ffff10;
    localparam logic [31:0] IRQ_MASK_IDX = 32'h05ffff11;
    localparam int          ADDR_SHIFT   = 2;

    localparam logic [31:0] RES_A_ADDR    = RES_A_IDX << ADDR_SHIFT;
    localparam logic [31:0] RES_B_ADDR    = RES_B_IDX << ADDR_SHIFT;
    localparam logic [31:0] RES_C_ADDR    = RES_C_IDX << ADDR_SHIFT;
    localparam logic [31:0] RES_D_ADDR    = RES_D_IDX << ADDR_SHIFT;
    localparam logic [31:0] CTRL_ADDR     = CTRL_IDX << ADDR_SHIFT;
    localparam logic [31:0] IRQ_STAT_ADDR = IRQ_STAT_IDX << ADDR_SHIFT;
    localparam logic [31:0] IRQ_MASK_ADDR = IRQ_MASK_IDX << ADDR_SHIFT;

    // Control/status layout and reset value
    localparam int         CTRL_W      = 8;
    localparam int         FLAG_BIT    = 7;
    localparam logic [7:0] CTRL_RESET  = 8'h04;

    // Result layout: left justified, low two result bits at 7 and 6
    localparam int RESULT_W   = 10;
    localparam int RES_REG_W  = 16;
    localparam int RES_LSB    = 6;
    localparam int RES_NUM    = 4;

    // Event status bits
    localparam int IRQ_W        = 2;
    localparam int IRQ_PASS_BIT = 0;
    localparam int IRQ_CONV_BIT = 1;

    // Conversion time in pclk cycles
    localparam int CONV_SLOW_CYCLES = 236;
    localparam int CONV_FAST_CYCLES = 134;
    localparam int CNT_W            = 8;

    typedef struct packed {
        logic       conv_end_flag;
        logic       conv_irq_enable;
        logic       conv_start_bit;
        logic       scan_mode;
        logic       conv_time_select;
        logic [2:0] input_select_field;
    } adc_ctrl_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } adc_state_type;

    // Request towards the analog multiplexer and converter core
    typedef struct packed {
        logic       active;
        logic [2:0] channel;
        logic       sample;
    } adc_core_req_type;

endpackage

// ### design/adc_ctrl.sv
// Summary of operation
// - Results read left justified: bits 9..2 at 15..8, bits 1..0 at 7..6.
// - End flag bit 7 clears only by writing zero or by standby; writing one keeps it.
// - Completion request follows end flag when interrupt enable bit 6 set.
// - Single mode: start bit 5 runs one conversion, then clears itself.
// - Scan mode bit 4: group converts repeatedly until start bit cleared.
//
// Register access over APB was left to the implementer.
module adc_ctrl #(
    parameter int SLOW_CYCLES = adc_pkg::CONV_SLOW_CYCLES,
    parameter int FAST_CYCLES = adc_pkg::CONV_FAST_CYCLES
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      standby,
    input  wire logic [adc_pkg::RESULT_W-1:0] core_result,
    output adc_pkg::adc_core_req_type      core_req,
    output logic                           conv_complete_irq,
    output logic                           irq
);

    typedef struct packed {
        adc_pkg::adc_state_type                st;
        adc_pkg::adc_ctrl_type                 ctrl;
        logic [adc_pkg::RES_NUM-1:0][adc_pkg::RES_REG_W-1:0] res;
        logic [adc_pkg::IRQ_W-1:0]             ists;
        logic [adc_pkg::IRQ_W-1:0]             imask;
        logic [adc_pkg::CNT_W-1:0]             cnt;
        logic [2:0]                            cur;
        logic                                  sample;
        logic [31:0]                           rdata;
    } adc_regs_type;

    localparam adc_regs_type REGS_RESET = '{
        st:      adc_pkg::ST_IDLE,
        ctrl:    adc_pkg::adc_ctrl_type'(adc_pkg::CTRL_RESET),
        res:     '0,
        ists:    '0,
        imask:   '0,
        cnt:     '0,
        cur:     '0,
        sample:  1'b0,
        rdata:   '0
    };

    localparam logic [adc_pkg::CNT_W-1:0] SLOW_LOAD =
        adc_pkg::CNT_W'(SLOW_CYCLES - 1);
    localparam logic [adc_pkg::CNT_W-1:0] FAST_LOAD =
        adc_pkg::CNT_W'(FAST_CYCLES - 1);

    adc_regs_type s_r;
    adc_regs_type s_nxt;

    logic        wr_acc;
    logic        rd_setup;
    logic        addr_hit;
    logic        wr_ctrl;
    logic        end_ev;
    logic        last_in_group;
    logic [1:0]  res_idx;
    logic [adc_pkg::CNT_W-1:0] cnt_load;
    adc_pkg::adc_ctrl_type     wctrl;

    // Bus decode; zero wait states, so the access phase is the last one
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign wctrl    = adc_pkg::adc_ctrl_type'(pwdata[adc_pkg::CTRL_W-1:0]);
    assign wr_ctrl  = wr_acc && (paddr == adc_pkg::CTRL_ADDR);

    always_comb begin
        unique case (paddr)
            adc_pkg::RES_A_ADDR,
            adc_pkg::RES_B_ADDR,
            adc_pkg::RES_C_ADDR,
            adc_pkg::RES_D_ADDR,
            adc_pkg::CTRL_ADDR,
            adc_pkg::IRQ_STAT_ADDR,
            adc_pkg::IRQ_MASK_ADDR: addr_hit = 1'b1;
            default:                addr_hit = 1'b0;
        endcase
    end

    // Conversion timing and group walk
    assign cnt_load = s_r.ctrl.conv_time_select ? FAST_LOAD
                                                : SLOW_LOAD;
    assign end_ev   = (s_r.st == adc_pkg::ST_CONV) && (s_r.cnt == '0);
    assign res_idx  = s_r.cur[1:0];
    assign last_in_group = !s_r.ctrl.scan_mode ||
        (s_r.cur[1:0] == s_r.ctrl.input_select_field[1:0]);

    // Next state: bus writes first, hardware events after so they win, except that a written start clear beats a conversion end
    always_comb begin
        s_nxt        = s_r;
        s_nxt.sample = 1'b0;

        if (wr_ctrl) begin
            s_nxt.ctrl.conv_irq_enable    = wctrl.conv_irq_enable;
            s_nxt.ctrl.conv_start_bit     = wctrl.conv_start_bit;
            s_nxt.ctrl.scan_mode          = wctrl.scan_mode;
            s_nxt.ctrl.conv_time_select   = wctrl.conv_time_select;
            s_nxt.ctrl.input_select_field = wctrl.input_select_field;
            // Only a written zero clears; a one leaves the flag alone
            if (!wctrl.conv_end_flag) begin
                s_nxt.ctrl.conv_end_flag = 1'b0;
            end
        end
        if (wr_acc && paddr == adc_pkg::IRQ_STAT_ADDR) begin
            s_nxt.ists = s_r.ists & ~pwdata[adc_pkg::IRQ_W-1:0];
        end
        if (wr_acc && paddr == adc_pkg::IRQ_MASK_ADDR) begin
            s_nxt.imask = pwdata[adc_pkg::IRQ_W-1:0];
        end

        unique case (s_r.st)
            adc_pkg::ST_IDLE: begin
                if (s_r.ctrl.conv_start_bit) begin
                    s_nxt.st  = adc_pkg::ST_CONV;
                    s_nxt.cnt = cnt_load;
                    // Scan groups begin at input 0 or input 4
                    s_nxt.cur = s_r.ctrl.scan_mode
                        ? {s_r.ctrl.input_select_field[2], 2'b00}
                        : s_r.ctrl.input_select_field;
                end
            end
            adc_pkg::ST_CONV: begin
                if (!s_nxt.ctrl.conv_start_bit) begin
                    // Software stop aborts; the partial result is dropped
                    s_nxt.st = adc_pkg::ST_IDLE;
                end else if (end_ev) begin
                    s_nxt.res[res_idx] = '0;
                    s_nxt.res[res_idx][adc_pkg::RES_REG_W-1:adc_pkg::RES_LSB]
                        = core_result;
                    s_nxt.sample = 1'b1;
                    s_nxt.ists[adc_pkg::IRQ_CONV_BIT] = 1'b1;
                    s_nxt.cnt = cnt_load;
                    if (last_in_group) begin
                        s_nxt.ctrl.conv_end_flag = 1'b1;
                        s_nxt.ists[adc_pkg::IRQ_PASS_BIT] = 1'b1;
                    end
                    if (!s_r.ctrl.scan_mode) begin
                        s_nxt.ctrl.conv_start_bit = 1'b0;
                        s_nxt.st = adc_pkg::ST_IDLE;
                    end else if (last_in_group) begin
                        // Wrap to the group start and keep going
                        s_nxt.cur = {s_r.ctrl.input_select_field[2],
                                     2'b00};
                    end else begin
                        s_nxt.cur = s_r.cur + 3'h1;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - adc_pkg::CNT_W'(1);
                end
            end
        endcase

        // Read data captured in setup so prdata comes from a flop
        if (rd_setup) begin
            unique case (paddr)
                adc_pkg::RES_A_ADDR: s_nxt.rdata = {16'h0000, s_r.res[0]};
                adc_pkg::RES_B_ADDR: s_nxt.rdata = {16'h0000, s_r.res[1]};
                adc_pkg::RES_C_ADDR: s_nxt.rdata = {16'h0000, s_r.res[2]};
                adc_pkg::RES_D_ADDR: s_nxt.rdata = {16'h0000, s_r.res[3]};
                adc_pkg::CTRL_ADDR:  s_nxt.rdata = {24'h000000, s_r.ctrl};
                adc_pkg::IRQ_STAT_ADDR:
                    s_nxt.rdata = {30'h00000000, s_r.ists};
                adc_pkg::IRQ_MASK_ADDR:
                    s_nxt.rdata = {30'h00000000, s_r.imask};
                default:             s_nxt.rdata = 32'h00000000;
            endcase
        end

        // Standby behaves like reset for the whole block
        if (standby) begin
            s_nxt = REGS_RESET;
        end
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= REGS_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign prdata   = s_r.rdata;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_hit;
    assign core_req = '{active:  (s_r.st == adc_pkg::ST_CONV),
                        channel: s_r.cur,
                        sample:  s_r.sample};
    assign conv_complete_irq = s_r.ctrl.conv_end_flag &&
                               s_r.ctrl.conv_irq_enable;
    assign irq = |(s_r.ists & s_r.imask);

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_result_justified;
        end_ev && s_r.ctrl.conv_start_bit && !standby && !(wr_ctrl &&
            !wctrl.conv_start_bit)
        |=> s_r.res[$past(res_idx)] ==
            {$past(core_result), 6'h00};
    endproperty
    a_result_justified: assert property (p_result_justified)
        else $error("result not stored left justified");

    property p_flag_write_one_keeps;
        wr_ctrl && wctrl.conv_end_flag && s_r.ctrl.conv_end_flag &&
            !standby
        |=> s_r.ctrl.conv_end_flag;
    endproperty
    a_flag_write_one_keeps: assert property (p_flag_write_one_keeps)
        else $error("writing one changed the end flag");

    property p_flag_rise_cause;
        $rose(s_r.ctrl.conv_end_flag) |-> $past(end_ev) &&
            $past(last_in_group);
    endproperty
    a_flag_rise_cause: assert property (p_flag_rise_cause)
        else $error("end flag set without a finished conversion");

    property p_irq_follows_flag;
        (s_r.ctrl.conv_end_flag && s_r.ctrl.conv_irq_enable)
            [*2] |-> conv_complete_irq ##1 (conv_complete_irq ||
            !s_r.ctrl.conv_end_flag || !s_r.ctrl.conv_irq_enable);
    endproperty
    a_irq_follows_flag: assert property (p_irq_follows_flag)
        else $error("completion request missing while flag set");

    property p_irq_masked;
        !s_r.ctrl.conv_irq_enable |-> !conv_complete_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("completion request while disabled");

    property p_single_self_clear;
        end_ev && !s_r.ctrl.scan_mode && s_r.ctrl.conv_start_bit &&
            !wr_ctrl && !standby
        |=> !s_r.ctrl.conv_start_bit && s_r.st == adc_pkg::ST_IDLE &&
            s_r.ctrl.conv_end_flag;
    endproperty
    a_single_self_clear: assert property (p_single_self_clear)
        else $error("single conversion did not clear start");

    property p_scan_continues;
        s_r.st == adc_pkg::ST_CONV && s_r.ctrl.scan_mode && !wr_ctrl &&
            !standby
        |=> s_r.st == adc_pkg::ST_CONV && s_r.ctrl.conv_start_bit;
    endproperty
    a_scan_continues: assert property (p_scan_continues)
        else $error("scan stopped without a clear");

    property p_conv_time;
        $rose(core_req.active) |-> s_r.cnt ==
            (s_r.ctrl.conv_time_select ? FAST_LOAD : SLOW_LOAD);
    endproperty
    a_conv_time: assert property (p_conv_time)
        else $error("conversion time load wrong");

    property p_channel_pick;
        s_r.st == adc_pkg::ST_IDLE && s_r.ctrl.conv_start_bit && !standby
        |=> s_r.cur == ($past(s_r.ctrl.scan_mode)
            ? {$past(s_r.ctrl.input_select_field[2]), 2'b00}
            : $past(s_r.ctrl.input_select_field));
    endproperty
    a_channel_pick: assert property (p_channel_pick)
        else $error("first channel of conversion wrong");

endmodule // adc_ctrl

// ### dv/adc_core_model.sv
// Stand-in for the analog multiplexer and converter core
module adc_core_model (
    input  wire logic                      pclk,
    input  wire adc_pkg::adc_core_req_type core_req,
    input  wire logic [6:0]                salt,
    output logic [adc_pkg::RESULT_W-1:0]   core_result
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [adc_pkg::RESULT_W-1:0] last_r = '0;

    // Previous value, so idle output keeps toggling
    always_ff @(posedge pclk) begin
        last_r <= core_result;
    end

    // Channel number in the top bits lets the bench tell results apart;
    // outside a conversion the value is garbage on purpose
    assign core_result = core_req.active ? {core_req.channel, salt} : ~last_r;
endmodule // adc_core_model

// ### dv/adc_control_registers_test.sv
// Self-checking bench for the converter control block
module adc_control_registers_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SLOW = 8;
    localparam int FAST = 4;

    logic                      pclk    = 1'b0;
    logic                      presetn = 1'b0;
    logic                      psel    = 1'b0;
    logic                      penable = 1'b0;
    logic                      pwrite  = 1'b0;
    logic                      standby = 1'b0;
    logic [31:0]               paddr   = '0;
    logic [31:0]               pwdata  = '0;
    logic [6:0]                salt    = '0;
    logic [31:0]               prdata, rd;
    logic                      pready, pslverr, err, conv_complete_irq, irq;
    logic [9:0]                core_result;
    adc_pkg::adc_core_req_type core_req;
    int                        n_mismatch = 0;
    int                        cmp_count  = 0;
    int                        act_cnt    = 0;
    int                        k, i;
    int                        ch_q[$];
    int                        prev_ch    = 0;

    adc_ctrl #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .standby(standby),
        .core_result(core_result), .core_req(core_req),
        .conv_complete_irq(conv_complete_irq), .irq(irq));

    adc_core_model u_core (
        .pclk(pclk), .core_req(core_req), .salt(salt),
        .core_result(core_result));

    initial begin
        forever #5 pclk = ~pclk;
    end

    // Busy cycles and the channel of every stored result; the sample
    // pulse comes a cycle late, when the channel may already have moved on
    always @(posedge pclk) begin
        if (core_req.active === 1'b1) act_cnt = act_cnt + 1;
        if (core_req.sample === 1'b1) ch_q.push_back(prev_ch);
        prev_ch = int'(core_req.channel);
    end

    function automatic logic [31:0] raddr(input int n);
        return adc_pkg::RES_A_ADDR + 32'(8 * n);
    endfunction

    // Model of a stored result: left justified, six zero bits below
    function automatic logic [31:0] exp_res(input logic [2:0] c);
        return {16'h0, c, salt, 6'h0};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; response taken at the edge that sees pready high
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    task automatic run_single(input logic [2:0] c, input logic t, ie);
        act_cnt = 0;
        apb(1'b1, adc_pkg::CTRL_ADDR, {24'h0, 1'b0, ie, 2'b10, t, c});
        k = 0;
        do begin
            apb(1'b0, adc_pkg::CTRL_ADDR, 32'h0);
            k++;
        end while (rd[5] !== 1'b0 && k < 40);
        if (k >= 40) n_mismatch++;
        chk("ctrl after single", rd, {24'h0, 1'b1, ie, 2'b00, t, c});
        chk("busy cycles", 32'(act_cnt), t ? FAST : SLOW);
        chk("completion irq", conv_complete_irq, ie);
        apb(1'b0, raddr(int'(c) % 4), 32'h0);
        chk("result", rd, exp_res(c));
    endtask

    initial begin
        k = $urandom(32'hb2d9);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, adc_pkg::CTRL_ADDR, 32'h0);
        chk("ctrl reset", rd, 32'h4);
        for (i = 0; i < 4; i++) begin
            apb(1'b0, raddr(i), 32'h0);
            chk("result reset", rd, 32'h0);
        end
        apb(1'b1, 32'h100, 32'hff);
        apb(1'b0, 32'h100, 32'h0);
        chk("unmapped data", rd, 32'h0);
        chk("unmapped error", err, 1'b1);
        $display("Reset and map test done");
        // Every channel once, random time select and salt
        for (i = 0; i < 8; i++) begin
            salt <= 7'($urandom);
            run_single(3'(i), 1'($urandom), 1'(i));
        end
        $display("Single mode test done");
        // Writing one to the end flag must not disturb it
        apb(1'b1, adc_pkg::CTRL_ADDR, 32'hc0);
        apb(1'b0, adc_pkg::CTRL_ADDR, 32'h0);
        chk("flag kept", rd[7], 1'b1);
        chk("irq kept", conv_complete_irq, 1'b1);
        apb(1'b1, adc_pkg::CTRL_ADDR, 32'h40);
        apb(1'b0, adc_pkg::CTRL_ADDR, 32'h0);
        chk("flag cleared", rd[7], 1'b0);
        chk("irq dropped", conv_complete_irq, 1'b0);
        // Event status, mask and write-one clear
        apb(1'b1, adc_pkg::IRQ_MASK_ADDR, 32'h0);
        apb(1'b0, adc_pkg::IRQ_STAT_ADDR, 32'h0);
        chk("event status", rd, 32'h3);
        chk("masked irq", irq, 1'b0);
        apb(1'b1, adc_pkg::IRQ_MASK_ADDR, 32'h2);
        apb(1'b0, adc_pkg::IRQ_MASK_ADDR, 32'h0);
        chk("unmasked irq", irq, 1'b1);
        apb(1'b1, adc_pkg::IRQ_STAT_ADDR, 32'h2);
        apb(1'b0, adc_pkg::IRQ_STAT_ADDR, 32'h0);
        chk("status cleared", rd, 32'h1);
        chk("irq cleared", irq, 1'b0);
        $display("Interrupt test done");
        // Scan group 4..5, fast, runs until software stops it
        ch_q.delete();
        apb(1'b1, adc_pkg::CTRL_ADDR, 32'h3d);
        k = 0;
        do begin
            apb(1'b0, adc_pkg::CTRL_ADDR, 32'h0);
            k++;
        end while (ch_q.size() < 5 && k < 40);
        if (k >= 40) n_mismatch++;
        chk("scan flag and start", rd[7:5], 3'b101);
        for (i = 0; i < 5; i++) begin
            chk("scan order", ch_q[i], 4 + i % 2);
        end
        apb(1'b1, adc_pkg::CTRL_ADDR, 32'h1d);
        apb(1'b0, raddr(1), 32'h0);
        chk("scan result", rd, exp_res(3'd5));
        chk("scan stopped", core_req.active, 1'b0);
        $display("Scan test done");
        // Standby in mid conversion clears everything
        apb(1'b1, adc_pkg::CTRL_ADDR, 32'h22);
        @(posedge pclk);
        standby <= 1'b1;
        @(posedge pclk);
        standby <= 1'b0;
        apb(1'b0, adc_pkg::CTRL_ADDR, 32'h0);
        chk("ctrl after standby", rd, 32'h4);
        apb(1'b0, raddr(1), 32'h0);
        chk("result after standby", rd, 32'h0);
        $display("Standby test done");
        tally_and_finish();
    end
endmodule // adc_control_registers_test
